// ### rtl/pesu_consts.svh
// offsets, bit positions, reset values and counts of the upper event status block
`ifndef PESU_CONSTS_SVH
`define PESU_CONSTS_SVH

// register byte offsets on the apb bus
`define PESU_OFF_STATUS    12'h000
`define PESU_OFF_PHASE     12'h004
`define PESU_OFF_THRESH    12'h008
`define PESU_OFF_CURRENT_PEAK_REGISTER     12'h00C
`define PESU_OFF_VOLTAGE_PEAK_REGISTER     12'h010
`define PESU_OFF_SETUP     12'h014

// status bit positions
`define PESU_BIT_CUR_A_ZX  12
`define PESU_BIT_RST_DONE  15
`define PESU_BIT_DIP       16
`define PESU_BIT_HI_CUR    17
`define PESU_BIT_HI_VOLT   18
`define PESU_BIT_ORDER     19
`define PESU_BIT_SUM_DIS   20
`define PESU_BIT_RSVD_ONE  21
`define PESU_BIT_RSVD_ZERO 22
`define PESU_BIT_I_PEAK    23
`define PESU_BIT_V_PEAK    24

// status masks and reset value
`define PESU_LIVE_MASK     32'h019F_F000
`define PESU_RSVD_ONE_MASK 32'h0020_0000
`define PESU_STATUS_RESET  32'h0000_8000

// per-phase status field positions
`define PESU_HC_PH_LSB     3
`define PESU_HV_PH_LSB     9
`define PESU_DIP_PH_LSB    12

// peak register layout, setup bit, power mode code, restore length
`define PESU_PEAK_PH_LSB   24
`define PESU_SETUP_SOFTWARE_RESET_BIT   7
`define PESU_PM_NORMAL     2'h0
`define PESU_RESTORE_CYC   4'h8

`endif

// ### rtl/pesu_order_check.sv
// watcher for a rising a crossing followed by c instead of b
module pesu_order_check (
	input  wire logic       core_clk,   // device clock
	input  wire logic       rst,        // async reset, high
	input  wire logic       clear,      // restore in progress
	input  wire logic [2:0] volt_rise,  // rising crossings c b a
	output logic            order_err   // one-cycle error pulse
);

	pesu_pkg::pesu_seq_e state_q;
	pesu_pkg::pesu_seq_e state_d;
	logic                err_d;

	// next crossing after a decides; a re-arms afterwards
	always_comb begin
		state_d = state_q;
		err_d   = 1'b0;
		unique case (state_q)
			pesu_pkg::PESU_SEQ_IDLE: begin
				if (volt_rise[0]) begin
					state_d = pesu_pkg::PESU_SEQ_ARMED;
				end
			end
			pesu_pkg::PESU_SEQ_ARMED: begin
				if (volt_rise[2] && !volt_rise[1]) begin
					err_d = 1'b1;
				end
				if (volt_rise[2] || volt_rise[1]) begin
					state_d = volt_rise[0] ? pesu_pkg::PESU_SEQ_ARMED : pesu_pkg::PESU_SEQ_IDLE;
				end
			end
		endcase
		if (clear) begin
			state_d = pesu_pkg::PESU_SEQ_IDLE;
			err_d   = 1'b0;
		end
	end

	// state and pulse registers
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q   <= pesu_pkg::PESU_SEQ_IDLE;
			order_err <= 1'b0;
		end else begin
			state_q   <= state_d;
			order_err <= err_d;
		end
	end

endmodule : pesu_order_check

// ### rtl/pesu_pkg.sv
// types shared by the upper event status block
package pesu_pkg;

	// block operating mode
	typedef enum logic {
		PESU_RUN,
		PESU_RESTORE
	} pesu_mode_e;

	// phase order watcher state
	typedef enum logic {
		PESU_SEQ_IDLE,
		PESU_SEQ_ARMED
	} pesu_seq_e;

	// one-cycle event pulses from the measurement datapath
	typedef struct packed {
		logic [2:0] cur_zx;      // current zero crossing, c b a
		logic       dip;         // voltage dip event
		logic [2:0] dip_ph;      // phases of the dip
		logic       hi_cur;      // overcurrent event
		logic [2:0] hi_cur_ph;   // phases of the overcurrent
		logic       hi_volt;     // overvoltage event
		logic [2:0] hi_volt_ph;  // phases of the overvoltage
		logic [2:0] volt_rise;   // rising voltage crossings, c b a
	} pesu_events_s;

	// end of a peak detection period
	typedef struct packed {
		logic        done;       // period ended this cycle
		logic [23:0] value;      // peak magnitude
		logic [2:0]  phase;      // phase where peak was seen
	} pesu_peak_s;

endpackage : pesu_pkg

// ### rtl/pesu_top.sv
// upper event status flags with apb access and reset-complete interrupt
//
// The register addresses and the APB register port were chosen for this implementation.
`include "pesu_consts.svh"

// Notes on behaviour
// - current zero crossing on phase a, b, c sets bits 12, 13, 14.
// - reset-complete bit 15 is 1 by default and after any reset or power return.
// - reset-complete set drives interrupt line one low; no enable can block it.
// - voltage dip sets bit 16; dip phases land in per-phase bits 14:12.
// - overcurrent sets bit 17; affected phases land in per-phase bits 5:3.
// - overvoltage sets bit 18; affected phases land in per-phase bits 11:9.
// - rising a crossing followed by c instead of b sets bit 19.
// - bit 20 sets when abs current sum and abs neutral differ beyond threshold.
// - bit 21 always reads 1; bits 22 and 31:25 always read 0.
// - current peak period end sets bit 23 and captures peak and phase.
// - voltage peak period end sets bit 24 and captures peak and phase.
module pesu_top #(
	parameter int ADDR_W = 12,  // apb address width
	parameter int SUM_W  = 24   // current sample width
) (
	input  wire logic                        core_clk,               // device clock, 50 mhz
	input  wire logic                        rst,                    // async reset, high
	input  wire logic                        psel,                   // apb select
	input  wire logic                        penable,                // apb access phase
	input  wire logic                        pwrite,                 // apb write
	input  wire logic [ADDR_W-1:0]           paddr,                  // apb byte address
	input  wire logic [31:0]                 pwdata,                 // apb write data
	output logic      [31:0]                 prdata,                 // apb read data
	output logic                             pready,                 // apb ready
	output logic                             pslverr,                // unmapped address
	input  wire pesu_pkg::pesu_events_s      events,                 // datapath event pulses
	input  wire logic                        sum_valid,              // new current sum sample
	input  wire logic signed [SUM_W-1:0]     current_sum_estimate,   // sum of phase currents
	input  wire logic signed [SUM_W-1:0]     neutral_current_sample, // neutral current
	input  wire pesu_pkg::pesu_peak_s        current_peak,           // current peak period end
	input  wire pesu_pkg::pesu_peak_s        voltage_peak,           // voltage peak period end
	input  wire logic [1:0]                  power_mode,             // present power mode
	output logic                             interrupt_line_one_n,   // interrupt, low active
	output logic                             restore_active          // registers reverting
);

	// magnitude of a signed sample
	function automatic logic [SUM_W-1:0] pesu_abs(input logic signed [SUM_W-1:0] v);
		return v[SUM_W-1] ? SUM_W'(-v) : SUM_W'(v);
	endfunction : pesu_abs

	// register state
	pesu_pkg::pesu_mode_e mode_q;
	pesu_pkg::pesu_mode_e mode_d;
	logic [3:0]           cnt_q;
	logic [3:0]           cnt_d;
	logic [1:0]           pm_prev_q;
	logic [31:0]          status_q;
	logic [31:0]          status_d;
	logic [31:0]          phase_q;
	logic [31:0]          phase_d;
	logic [SUM_W-1:0]     thresh_q;
	logic [31:0]          current_peak_register_q;
	logic [31:0]          voltage_peak_register_q;

	// apb decode
	logic        setup_w;
	logic        wr_w;
	logic        hit_status;
	logic        hit_phase;
	logic        hit_thresh;
	logic        hit_current_peak_register;
	logic        hit_voltage_peak_register;
	logic        hit_setup;
	logic        mapped_w;
	logic [31:0] status_rd_w;
	logic [31:0] rd_w;

	assign setup_w     = psel && !penable;
	assign wr_w        = psel && penable && pready && pwrite;
	assign hit_status  = paddr == ADDR_W'(`PESU_OFF_STATUS);
	assign hit_phase   = paddr == ADDR_W'(`PESU_OFF_PHASE);
	assign hit_thresh  = paddr == ADDR_W'(`PESU_OFF_THRESH);
	assign hit_current_peak_register   = paddr == ADDR_W'(`PESU_OFF_CURRENT_PEAK_REGISTER);
	assign hit_voltage_peak_register   = paddr == ADDR_W'(`PESU_OFF_VOLTAGE_PEAK_REGISTER);
	assign hit_setup   = paddr == ADDR_W'(`PESU_OFF_SETUP);
	assign mapped_w    = hit_status | hit_phase | hit_thresh | hit_current_peak_register | hit_voltage_peak_register | hit_setup;

	// fixed reserved bits forced on every read
	assign status_rd_w = (status_q & `PESU_LIVE_MASK) | `PESU_RSVD_ONE_MASK;

	// read selection; setup register reads as zero
	assign rd_w = hit_status ? status_rd_w :
	              hit_phase  ? phase_q :
	              hit_thresh ? 32'(thresh_q) :
	              hit_current_peak_register  ? current_peak_register_q :
	              hit_voltage_peak_register  ? voltage_peak_register_q : 32'h0;

	// restore triggers
	logic start_w;
	logic software_reset_bit_w;
	logic pm_ret_w;
	logic done_w;
	logic run_w;

	assign software_reset_bit_w  = wr_w && hit_setup && pwdata[`PESU_SETUP_SOFTWARE_RESET_BIT];
	assign pm_ret_w = (pm_prev_q != `PESU_PM_NORMAL) && (power_mode == `PESU_PM_NORMAL);
	assign start_w  = software_reset_bit_w || pm_ret_w;
	assign done_w   = (mode_q == pesu_pkg::PESU_RESTORE) && (cnt_q == 4'h0) && !start_w;
	assign run_w    = (mode_q == pesu_pkg::PESU_RUN) && !start_w;

	// restore sequencer
	always_comb begin
		mode_d = mode_q;
		cnt_d  = cnt_q;
		unique case (mode_q)
			pesu_pkg::PESU_RUN: begin
				cnt_d = 4'h0;
			end
			pesu_pkg::PESU_RESTORE: begin
				if (cnt_q == 4'h0) begin
					mode_d = pesu_pkg::PESU_RUN;
				end else begin
					cnt_d = cnt_q - 4'h1;
				end
			end
		endcase
		if (start_w) begin
			mode_d = pesu_pkg::PESU_RESTORE;
			cnt_d  = `PESU_RESTORE_CYC - 4'h1;
		end
	end

	// phase order watcher
	logic order_err_w;

	pesu_order_check u_order (
		.core_clk  (core_clk),
		.rst       (rst),
		.clear     (!run_w),
		.volt_rise (events.volt_rise),
		.order_err (order_err_w)
	);

	// current sum disagreement
	logic [SUM_W-1:0] abs_sum_w;
	logic [SUM_W-1:0] abs_neu_w;
	logic [SUM_W-1:0] gap_w;
	logic             mism_w;

	assign abs_sum_w = pesu_abs(current_sum_estimate);
	assign abs_neu_w = pesu_abs(neutral_current_sample);
	assign gap_w     = (abs_sum_w >= abs_neu_w) ? abs_sum_w - abs_neu_w : abs_neu_w - abs_sum_w;
	assign mism_w    = sum_valid && (gap_w > thresh_q);

	// set and clear vectors of the status flags
	logic [31:0] set_w;
	logic [31:0] clr_w;

	assign set_w = run_w ? (32'(events.cur_zx) << `PESU_BIT_CUR_A_ZX
	                      | 32'(events.dip) << `PESU_BIT_DIP
	                      | 32'(events.hi_cur) << `PESU_BIT_HI_CUR
	                      | 32'(events.hi_volt) << `PESU_BIT_HI_VOLT
	                      | 32'(order_err_w) << `PESU_BIT_ORDER
	                      | 32'(mism_w) << `PESU_BIT_SUM_DIS
	                      | 32'(current_peak.done) << `PESU_BIT_I_PEAK
	                      | 32'(voltage_peak.done) << `PESU_BIT_V_PEAK) : 32'h0;
	assign clr_w = (wr_w && hit_status) ? pwdata : 32'h0;

	// new status: set wins over clear, restore empties it, end of restore marks done
	assign status_d = !(run_w || done_w) ? 32'h0 :
	                  ((((status_q & ~clr_w) | set_w) & `PESU_LIVE_MASK)
	                  | (done_w ? `PESU_STATUS_RESET : 32'h0));

	// per-phase fields accumulate until their flag is cleared
	logic [2:0] dip_ph_w;
	logic [2:0] hc_ph_w;
	logic [2:0] hv_ph_w;

	assign dip_ph_w = (clr_w[`PESU_BIT_DIP] ? 3'h0 : phase_q[`PESU_DIP_PH_LSB +: 3])
	                | (set_w[`PESU_BIT_DIP] ? events.dip_ph : 3'h0);
	assign hc_ph_w  = (clr_w[`PESU_BIT_HI_CUR] ? 3'h0 : phase_q[`PESU_HC_PH_LSB +: 3])
	                | (set_w[`PESU_BIT_HI_CUR] ? events.hi_cur_ph : 3'h0);
	assign hv_ph_w  = (clr_w[`PESU_BIT_HI_VOLT] ? 3'h0 : phase_q[`PESU_HV_PH_LSB +: 3])
	                | (set_w[`PESU_BIT_HI_VOLT] ? events.hi_volt_ph : 3'h0);

	// assemble per-phase register
	always_comb begin
		phase_d = 32'h0;
		if (run_w) begin
			phase_d[`PESU_DIP_PH_LSB +: 3] = dip_ph_w;
			phase_d[`PESU_HC_PH_LSB +: 3]  = hc_ph_w;
			phase_d[`PESU_HV_PH_LSB +: 3]  = hv_ph_w;
		end
	end

	// sequencer, power mode history and flags
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			mode_q    <= pesu_pkg::PESU_RUN;
			cnt_q     <= 4'h0;
			pm_prev_q <= `PESU_PM_NORMAL;
			status_q  <= `PESU_STATUS_RESET;
			phase_q   <= 32'h0;
		end else begin
			mode_q    <= mode_d;
			cnt_q     <= cnt_d;
			pm_prev_q <= power_mode;
			status_q  <= status_d;
			phase_q   <= phase_d;
		end
	end

	// threshold and peak captures
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			thresh_q <= '0;
			current_peak_register_q  <= 32'h0;
			voltage_peak_register_q  <= 32'h0;
		end else if (!run_w) begin
			thresh_q <= '0;
			current_peak_register_q  <= 32'h0;
			voltage_peak_register_q  <= 32'h0;
		end else begin
			if (wr_w && hit_thresh) begin
				thresh_q <= pwdata[SUM_W-1:0];
			end
			if (current_peak.done) begin
				current_peak_register_q <= {5'h0, current_peak.phase, current_peak.value};
			end
			if (voltage_peak.done) begin
				voltage_peak_register_q <= {5'h0, voltage_peak.phase, voltage_peak.value};
			end
		end
	end

	// apb answer one cycle after setup; outputs straight from flops
	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			prdata               <= 32'h0;
			pready               <= 1'b0;
			pslverr              <= 1'b0;
			interrupt_line_one_n <= 1'b0;
			restore_active       <= 1'b0;
		end else begin
			pready               <= setup_w;
			pslverr              <= setup_w && !mapped_w;
			prdata               <= (setup_w && !pwrite) ? rd_w : 32'h0;
			interrupt_line_one_n <= !status_d[`PESU_BIT_RST_DONE];
			restore_active       <= mode_d == pesu_pkg::PESU_RESTORE;
		end
	end

	// checks on the flag behaviour
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	sequence s_sw_reset;
		wr_w && hit_setup && pwdata[`PESU_SETUP_SOFTWARE_RESET_BIT];
	endsequence

	sequence s_order_fault;
		run_w && events.volt_rise == 3'h1 ##1 run_w && events.volt_rise == 3'h4;
	endsequence

	AST_ZX_SET: assert property (run_w && events.cur_zx[0] |=> status_q[`PESU_BIT_CUR_A_ZX])
		else $error("current a crossing did not set its flag");
	AST_RST_DONE: assert property (s_sw_reset |=> !status_q[`PESU_BIT_RST_DONE] ##[8:8]
	                              (status_q[`PESU_BIT_RST_DONE] || $past(start_w)))
		else $error("reset complete flag not set after restore");
	AST_IRQ_LOW: assert property ($past(status_q[`PESU_BIT_RST_DONE]) == status_q[`PESU_BIT_RST_DONE]
	                             |-> interrupt_line_one_n == !status_q[`PESU_BIT_RST_DONE])
		else $error("interrupt line does not follow reset complete flag");
	AST_DIP: assert property (run_w && events.dip |=> status_q[`PESU_BIT_DIP]
	                         && ((phase_q[`PESU_DIP_PH_LSB +: 3] & $past(events.dip_ph)) == $past(events.dip_ph)))
		else $error("dip flag or phases not recorded");
	AST_HI_CUR: assert property (run_w && events.hi_cur |=> status_q[`PESU_BIT_HI_CUR]
	                            && ((phase_q[`PESU_HC_PH_LSB +: 3] & $past(events.hi_cur_ph))
	                                == $past(events.hi_cur_ph)))
		else $error("overcurrent flag or phases not recorded");
	AST_HI_VOLT: assert property (run_w && events.hi_volt |=> status_q[`PESU_BIT_HI_VOLT]
	                             && ((phase_q[`PESU_HV_PH_LSB +: 3] & $past(events.hi_volt_ph))
	                                 == $past(events.hi_volt_ph)))
		else $error("overvoltage flag or phases not recorded");
	AST_ORDER: assert property (s_order_fault ##1 run_w |=> status_q[`PESU_BIT_ORDER])
		else $error("a then c crossing did not flag order error");
	AST_SUM_DIS: assert property (run_w && sum_valid && gap_w > thresh_q |=> status_q[`PESU_BIT_SUM_DIS])
		else $error("sum disagreement not flagged");
	AST_RSVD: assert property (status_rd_w[`PESU_BIT_RSVD_ONE] && !status_rd_w[`PESU_BIT_RSVD_ZERO]
	                          && status_rd_w[31:25] == 7'h0)
		else $error("reserved status bits read wrong");
	AST_I_PEAK: assert property (run_w && current_peak.done |=> status_q[`PESU_BIT_I_PEAK]
	                            && current_peak_register_q[23:0] == $past(current_peak.value))
		else $error("current peak not flagged or captured");
	AST_V_PEAK: assert property (run_w && voltage_peak.done |=> status_q[`PESU_BIT_V_PEAK]
	                            && voltage_peak_register_q[`PESU_PEAK_PH_LSB +: 3] == $past(voltage_peak.phase))
		else $error("voltage peak not flagged or captured");
	AST_W1C_KEEP: assert property (run_w && wr_w && hit_status && status_q[`PESU_BIT_DIP]
	                              && !pwdata[`PESU_BIT_DIP] |=> status_q[`PESU_BIT_DIP])
		else $error("writing zero cleared a flag");
	AST_W1C_CLR: assert property (run_w && wr_w && hit_status && pwdata[`PESU_BIT_HI_CUR]
	                             && !events.hi_cur |=> !status_q[`PESU_BIT_HI_CUR])
		else $error("writing one did not clear a flag");

	// a power return restarts the same restore as a software reset
	sequence s_power_return;
		pm_ret_w;
	endsequence

	// a status read in its setup cycle
	sequence s_status_read;
		setup_w && !pwrite && hit_status;
	endsequence

	// each current crossing sets its own flag
	for (genvar gi = 0; gi < 3; gi++) begin : g_zx
		AST_ZX_PH: assert property (run_w && events.cur_zx[gi] |=> status_q[`PESU_BIT_CUR_A_ZX + gi])
			else $error("current crossing did not set its flag");
	end

	// restore window: flags empty, interrupt released, flag back after eight cycles
	AST_RST_DONE_PM: assert property (s_power_return |=> !status_q[`PESU_BIT_RST_DONE] ##8
	                                 (status_q[`PESU_BIT_RST_DONE] || $past(start_w)))
		else $error("reset complete flag not set after power return");
	AST_RESTORE_EMPTY: assert property (restore_active |-> status_q == 32'h0 && phase_q == 32'h0)
		else $error("flags not emptied during restore");
	AST_IRQ_RESTORE: assert property (restore_active |-> interrupt_line_one_n)
		else $error("interrupt line low during restore");
	AST_IRQ_NMI: assert property (status_q[`PESU_BIT_RST_DONE] |-> !interrupt_line_one_n)
		else $error("interrupt line high while reset complete flag set");

	// gap at or below the threshold leaves the flag clear
	AST_SUM_QUIET: assert property (run_w && sum_valid && gap_w <= thresh_q
	                               && !status_q[`PESU_BIT_SUM_DIS] |=> !status_q[`PESU_BIT_SUM_DIS])
		else $error("sum disagreement flagged at or below threshold");

	// reserved bits as the host sees them
	AST_RSVD_READ: assert property (s_status_read |=> prdata[`PESU_BIT_RSVD_ONE]
	                               && !prdata[`PESU_BIT_RSVD_ZERO] && prdata[31:25] == 7'h0)
		else $error("reserved status bits read wrong on the bus");

	// the other half of each peak capture
	AST_I_PEAK_PH: assert property (run_w && current_peak.done |=> current_peak_register_q[`PESU_PEAK_PH_LSB +: 3]
	                               == $past(current_peak.phase))
		else $error("current peak phase not captured");
	AST_V_PEAK_VAL: assert property (run_w && voltage_peak.done
	                                |=> voltage_peak_register_q[23:0] == $past(voltage_peak.value))
		else $error("voltage peak value not captured");

endmodule : pesu_top

// ### testbench/pesu_host_model.sv
// apb host model that reads the event flags and clears them
module pesu_host_model (
	input  wire logic        core_clk, // device clock
	output logic             psel,     // apb select
	output logic             penable,  // apb access phase
	output logic             pwrite,   // apb write
	output logic [11:0]      paddr,    // apb byte address
	output logic [31:0]      pwdata,   // apb write data
	input  wire logic [31:0] prdata,   // apb read data
	input  wire logic        pready,   // apb ready
	input  wire logic        pslverr   // apb error
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus idle from time zero
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// one transfer, request held until pready is sampled high
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e);
		@(posedge core_clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'h1;
		@(posedge core_clk);
		while (pready !== 1'h1) @(posedge core_clk);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer

	// flags are cleared by writing ones, zero bits leave them alone
	task automatic clear_flags(input logic [31:0] m);
		logic [31:0] r;
		logic        e;
		xfer(1'h1, 12'h000, m, r, e);
	endtask : clear_flags
endmodule : pesu_host_model

// ### testbench/pesu_top_test.sv
// self-checking bench for the upper event status block
`include "pesu_consts.svh"
module pesu_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic                    core_clk, rst, psel, penable, pwrite, pready, pslverr, irq_n, restore_active;
	logic                    sum_valid;
	logic [11:0]             paddr;
	logic [31:0]             pwdata, prdata;
	logic [1:0]              power_mode;
	logic signed [23:0]      cs, ns;
	pesu_pkg::pesu_events_s  ev;
	pesu_pkg::pesu_peak_s    ipk, vpk;
	int                      errors, checks, cycles;

	pesu_top u_pesu_top (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .events(ev),
		.sum_valid(sum_valid), .current_sum_estimate(cs), .neutral_current_sample(ns), .current_peak(ipk),
		.voltage_peak(vpk), .power_mode(power_mode), .interrupt_line_one_n(irq_n), .restore_active(restore_active));
	pesu_host_model u_pesu_host_model (.core_clk(core_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// clock and hang guard
	always #10 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			results();
		end
	end

	// verdict and end of run
	task automatic results();
		if (errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : results

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	// register access helpers
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		u_pesu_host_model.xfer(1'h1, a, d, r, e);
	endtask : wr
	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		u_pesu_host_model.xfer(1'h0, a, 32'h0000_0000, r, e);
		chk(r, exp, "read data");
	endtask : rdchk

	// one-cycle event pulse
	task automatic pulse(input pesu_pkg::pesu_events_s e);
		@(posedge core_clk);
		ev <= e;
		@(posedge core_clk);
		ev <= '0;
		repeat (2) @(posedge core_clk);
	endtask : pulse

	// one current sum sample
	task automatic sample(input logic [23:0] s, input logic [23:0] n);
		@(posedge core_clk);
		sum_valid <= 1'h1;
		cs <= s;
		ns <= n;
		@(posedge core_clk);
		sum_valid <= 1'h0;
		repeat (2) @(posedge core_clk);
	endtask : sample

	// waits out a restore, interrupt released meanwhile
	task automatic restore_wait();
		int n;
		n = 0;
		while (restore_active !== 1'h1 && n < 20) begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		chk({31'h0, irq_n}, 32'h1, "irq during restore");
		while (restore_active !== 1'h0 && n < 40) begin
			@(posedge core_clk);
			n++;
		end
		@(posedge core_clk);
		chk({31'h0, irq_n}, 32'h0, "irq after restore");
		rdchk(`PESU_OFF_STATUS, 32'h0020_8000);
		rdchk(`PESU_OFF_THRESH, 32'h0000_0000);
	endtask : restore_wait

	// reset value and write-one-to-clear of the reset-complete flag
	task automatic t_reset_flag();
		chk({31'h0, irq_n}, 32'h0, "irq after reset");
		rdchk(`PESU_OFF_STATUS, 32'h0020_8000);
		wr(`PESU_OFF_STATUS, 32'h0000_0000);
		rdchk(`PESU_OFF_STATUS, 32'h0020_8000);
		u_pesu_host_model.clear_flags(32'h0000_8000);
		rdchk(`PESU_OFF_STATUS, 32'h0020_0000);
		chk({31'h0, irq_n}, 32'h1, "irq after clear");
	endtask : t_reset_flag

	// zero crossings, dip, overcurrent and overvoltage with phases
	task automatic t_events();
		pesu_pkg::pesu_events_s e;
		for (int i = 0; i < 3; i++) begin
			e = '0;
			e.cur_zx = 3'h1 << i;
			pulse(e);
			rdchk(`PESU_OFF_STATUS, 32'h0020_0000 | (32'h0000_1000 << i));
			u_pesu_host_model.clear_flags(32'h0000_1000 << i);
		end
		e = '0;
		e.dip = 1'h1;
		e.dip_ph = 3'h5;
		e.hi_cur = 1'h1;
		e.hi_cur_ph = 3'h2;
		e.hi_volt = 1'h1;
		e.hi_volt_ph = 3'h3;
		pulse(e);
		rdchk(`PESU_OFF_STATUS, 32'h0027_0000);
		rdchk(`PESU_OFF_PHASE, 32'h0000_5610);
		u_pesu_host_model.clear_flags(32'h0002_0000);
		rdchk(`PESU_OFF_PHASE, 32'h0000_5600);
		e = '0;
		e.dip = 1'h1;
		e.dip_ph = 3'h2;
		pulse(e);
		rdchk(`PESU_OFF_PHASE, 32'h0000_7600);
		u_pesu_host_model.clear_flags(32'h0007_0000);
		rdchk(`PESU_OFF_PHASE, 32'h0000_0000);
		rdchk(`PESU_OFF_STATUS, 32'h0020_0000);
	endtask : t_events

	// phase order: a then c is an error, a then b then c is not
	task automatic t_order();
		pesu_pkg::pesu_events_s e;
		e = '0;
		e.volt_rise = 3'h1;
		pulse(e);
		e.volt_rise = 3'h4;
		pulse(e);
		rdchk(`PESU_OFF_STATUS, 32'h0028_0000);
		u_pesu_host_model.clear_flags(32'h0008_0000);
		for (int i = 0; i < 3; i++) begin
			e.volt_rise = 3'h1 << i;
			pulse(e);
		end
		rdchk(`PESU_OFF_STATUS, 32'h0020_0000);
		@(posedge core_clk);
		e.volt_rise = 3'h1;
		ev <= e;
		@(posedge core_clk);
		e.volt_rise = 3'h4;
		ev <= e;
		@(posedge core_clk);
		ev <= '0;
		repeat (2) @(posedge core_clk);
		rdchk(`PESU_OFF_STATUS, 32'h0028_0000);
		u_pesu_host_model.clear_flags(32'h0008_0000);
	endtask : t_order

	// current sum disagreement above and at the threshold
	task automatic t_sum();
		wr(`PESU_OFF_THRESH, 32'h0000_0064);
		rdchk(`PESU_OFF_THRESH, 32'h0000_0064);
		sample(24'hFFFED4, 24'h000096);
		rdchk(`PESU_OFF_STATUS, 32'h0030_0000);
		u_pesu_host_model.clear_flags(32'h0010_0000);
		sample(24'hFFFF38, 24'h000064);
		rdchk(`PESU_OFF_STATUS, 32'h0020_0000);
	endtask : t_sum

	// end of current and voltage peak periods
	task automatic t_peak();
		pesu_pkg::pesu_peak_s p;
		p = '{done: 1'h1, value: 24'hABCDE1, phase: 3'h4};
		@(posedge core_clk);
		ipk <= p;
		p.done = 1'h0;
		@(posedge core_clk);
		ipk <= p;
		p = '{done: 1'h1, value: 24'h123456, phase: 3'h1};
		vpk <= p;
		p.done = 1'h0;
		@(posedge core_clk);
		vpk <= p;
		rdchk(`PESU_OFF_STATUS, 32'h01A0_0000);
		rdchk(`PESU_OFF_CURRENT_PEAK_REGISTER, 32'h04AB_CDE1);
		rdchk(`PESU_OFF_VOLTAGE_PEAK_REGISTER, 32'h0112_3456);
		u_pesu_host_model.clear_flags(32'h0180_0000);
		wr(`PESU_OFF_STATUS, 32'hFFFF_FFFF);
		rdchk(`PESU_OFF_STATUS, 32'h0020_0000);
	endtask : t_peak

	// unmapped address, then software reset and power return
	task automatic t_restore();
		logic [31:0]            r;
		logic                   e;
		logic [1:0]             pm;
		pesu_pkg::pesu_events_s ez;
		u_pesu_host_model.xfer(1'h0, 12'h020, 32'h0000_0000, r, e);
		chk({31'h0, e}, 32'h1, "unmapped error");
		chk(r, 32'h0000_0000, "unmapped data");
		ez = '0;
		ez.cur_zx = 3'h1;
		pulse(ez);
		wr(`PESU_OFF_SETUP, 32'h0000_0080);
		restore_wait();
		u_pesu_host_model.clear_flags(32'h0000_8000);
		for (int m = 1; m < 4; m++) begin
			pm = 2'(m);
			@(posedge core_clk);
			power_mode <= pm;
			repeat (3) @(posedge core_clk);
			power_mode <= 2'h0;
			restore_wait();
		end
	endtask : t_restore

	// main sequence
	initial begin
		core_clk = 1'h0;
		rst = 1'h1;
		ev = '0;
		ipk = '0;
		vpk = '0;
		sum_valid = 1'h0;
		cs = 24'h000000;
		ns = 24'h000000;
		power_mode = 2'h0;
		errors = 0;
		checks = 0;
		cycles = 0;
		repeat (10) @(posedge core_clk);
		rst <= 1'h0;
		t_reset_flag();
		t_events();
		t_order();
		t_sum();
		t_peak();
		t_restore();
		results();
	end
endmodule : pesu_top_test
